// [hdl/breaker_failure_stage.v]
/*
 * breaker failure supervision stage with ahb-lite register slave.
 * watches the control level of the selected primary trip output, times it
 * in milliseconds and drives a separate backup relay; keeps counters, a
 * shared force flag with timeout and the eight latest fault records.
 * assumes: trip output levels, block and time stamps come from logic on
 * mclk; the bus is a single-master ahb-lite with word transfers only.
 */
`timescale 1ns/100ps
`include "breaker_failure_regs.vh"

// Function
// - time the selected trip relay control level
// - backup relay on after operate time passes
// - backup held until primary relay releases
// - all stages on that relay are covered
// - backup uses its own separate output
// - status reads blocked, started or tripped
// - start and trip writable only under force
// - start and trip counters, clearable
// - shared force flag clears after five minutes
// - setting selects trip output one or two
// - relay selection shared with breaker monitoring
// - eight latest faults kept, oldest replaced
// - elapsed delay percent, 100 means trip
// - record stamp holds date and milliseconds time
module breaker_failure_stage #(
   parameter MS_CYCLES        = `MS_CYCLES,  // clocks per millisecond
   parameter FORCE_TIMEOUT_MS = `FORCE_MS    // force flag lifetime
) (
   input  wire        mclk,             // system clock, 125 MHz
   input  wire        rst_n,            // synchronous reset, active low
   input  wire        hsel,             // ahb slave select
   input  wire [31:0] haddr,            // ahb address
   input  wire [1:0]  htrans,           // ahb transfer type
   input  wire        hwrite,           // ahb write
   input  wire [2:0]  hsize,            // ahb size, word only
   input  wire [31:0] hwdata,           // ahb write data
   input  wire        hready,           // ahb bus ready
   output wire        hreadyout,        // ahb slave ready
   output wire        hresp,            // ahb response, always okay
   output reg  [31:0] hrdata,           // ahb read data
   input  wire        trip_output_one,  // control level of first trip relay
   input  wire        trip_output_two,  // control level of second trip relay
   input  wire        stage_block,      // blocking level
   input  wire [31:0] date_stamp,       // current date, packed yyyy-mm-dd
   input  wire [31:0] time_stamp,       // milliseconds since midnight
   output reg         backup_relay,     // backup trip output
   output reg  [1:0]  cbm_relay_sel,    // selection for breaker monitoring
   output reg         stage_started,    // stage is timing
   output reg         stage_tripped     // stage has tripped
);

   // ========================================================================
   // declarations
   localparam S_IDLE    = 2'b00;        // waiting for a trip command
   localparam S_BLOCKED = 2'b01;        // held off by the block input
   localparam S_STARTED = 2'b10;        // timing the trip command
   localparam S_TRIPPED = 2'b11;        // backup relay energised

   localparam [19:0] MS_LIMIT    = MS_CYCLES[19:0];         // prescaler wrap
   localparam [19:0] FORCE_LIMIT = FORCE_TIMEOUT_MS[19:0];  // timeout wrap

   reg  [1:0]  state_q;                 // stage state
   reg  [1:0]  state_d;                 // next stage state
   reg  [19:0] elapsed_q;               // milliseconds of the trip command
   reg  [19:0] elapsed_d;               // next elapsed count
   reg  [19:0] optime_q;                // operate time in milliseconds
   reg  [1:0]  sel_q;                   // supervised relay, 1 or 2
   reg         force_q;                 // shared force flag
   reg         forced_q;                // state set by software under force
   reg  [31:0] start_cnt_q;             // cumulative starts
   reg  [31:0] trip_cnt_q;              // cumulative trips
   reg  [2:0]  rec_sel_q;               // record view, 0 = latest
   reg  [2:0]  wr_ptr_q;                // next record slot
   reg  [3:0]  fill_q;                  // valid records
   reg  [31:0] pend_date_q;             // stamp of the running fault
   reg  [31:0] pend_time_q;             // stamp of the running fault
   reg  [31:0] date_mem [0:7];          // record dates
   reg  [31:0] time_mem [0:7];          // record times
   reg  [6:0]  elapsed_delay_percent_mem [0:7];          // record elapsed percent
   reg         wr_pend_q;               // data phase write pending
   reg  [7:0]  wr_addr_q;               // data phase address
   reg         start_ev;                // stage started this cycle
   reg         trip_ev;                 // stage tripped this cycle
   reg         drop_ev;                 // early drop this cycle
   reg  [31:0] rd_d;                    // read data for next data phase
   wire        sup_w;                   // supervised control level
   wire        ms_tick;                 // one-millisecond pulse
   wire        force_expired;           // force timeout pulse
   wire        div_busy;                // divider running
   wire        div_done;                // divider result valid
   wire [6:0]  div_pct;                 // divider result
   wire [2:0]  rd_slot_w;               // slot shown to software
   wire        addr_ok_w;               // valid address phase
   wire        ctrl_wr_w;               // control register write
   wire        status_wr_w;             // status register write
   wire        rec_wr_w;                // a fault record is written now
   wire [6:0]  rec_pct_w;               // percent for that record
   wire [27:0] pct_num_w;               // elapsed times 100

   // ========================================================================
   // bus slave: zero wait states, okay only
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign addr_ok_w   = hsel && htrans[1] && hready;
   assign ctrl_wr_w   = wr_pend_q && (wr_addr_q == `CTRL_OFS);
   assign status_wr_w = wr_pend_q && (wr_addr_q == `STATUS_OFS);
   assign rd_slot_w   = wr_ptr_q - 3'h1 - rec_sel_q;

   // read mux, looked up in the address phase
   always @* begin
      rd_d = 32'h0000_0000;
      if (haddr[7:0] == `CTRL_OFS) begin
         rd_d[`CTRL_FORCE_BIT] = force_q;
         rd_d[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = sel_q;
      end else if (haddr[7:0] == `OPTIME_OFS) begin
         rd_d[19:0] = optime_q;
      end else if (haddr[7:0] == `STATUS_OFS) begin
         rd_d[`ST_BLOCKED_BIT] = (state_q == S_BLOCKED);
         rd_d[`ST_STARTED_BIT] = (state_q == S_STARTED);
         rd_d[`ST_TRIPPED_BIT] = (state_q == S_TRIPPED);
      end else if (haddr[7:0] == `START_CNT_OFS) begin
         rd_d = start_cnt_q;
      end else if (haddr[7:0] == `TRIP_CNT_OFS) begin
         rd_d = trip_cnt_q;
      end else if (haddr[7:0] == `REC_SEL_OFS) begin
         rd_d[2:0] = rec_sel_q;
      end else if (haddr[7:0] == `REC_DATE_OFS) begin
         rd_d = date_mem[rd_slot_w];
      end else if (haddr[7:0] == `REC_TIME_OFS) begin
         rd_d = time_mem[rd_slot_w];
      end else if (haddr[7:0] == `REC_ELAPSED_DELAY_PERCENT_OFS) begin
         rd_d[6:0] = elapsed_delay_percent_mem[rd_slot_w];
      end else if (haddr[7:0] == `REC_FILL_OFS) begin
         rd_d[3:0] = fill_q;
      end
   end

   // address phase capture; unmapped or upper addresses read zero
   always @(posedge mclk) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata    <= 32'h0000_0000;
      end else begin
         wr_pend_q <= addr_ok_w && hwrite;
         if (addr_ok_w) begin
            wr_addr_q <= haddr[7:0];
            hrdata    <= (haddr[31:8] == 24'h00_0000) ? rd_d : 32'h0000_0000;
         end
      end
   end

   // ========================================================================
   // settings: operate time, relay selection, record view
   // the password check lives in the software that owns this bus
   always @(posedge mclk) begin
      if (!rst_n) begin
         optime_q      <= `OPTIME_RST;
         sel_q         <= `SEL_RST;
         rec_sel_q     <= 3'h0;
         cbm_relay_sel <= `SEL_RST;
      end else begin
         if (wr_pend_q && (wr_addr_q == `OPTIME_OFS))
            optime_q <= hwdata[19:0];
         if (wr_pend_q && (wr_addr_q == `REC_SEL_OFS))
            rec_sel_q <= hwdata[2:0];
         // only outputs one and two exist; other codes ignored
         if (ctrl_wr_w &&
             ((hwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB] == `SEL_FIRST) ||
              (hwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB] == `SEL_SECOND)))
            sel_q <= hwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
         // same selection handed to breaker monitoring
         cbm_relay_sel <= sel_q;
      end
   end

   // ========================================================================
   // force flag with timeout
   // one flag for all stages, dropped after five minutes
   always @(posedge mclk) begin
      if (!rst_n) begin
         force_q <= 1'b0;
      end else if (ctrl_wr_w) begin
         // a write in the expiry cycle wins and restarts the timeout
         force_q <= hwdata[`CTRL_FORCE_BIT];
      end else if (force_expired) begin
         force_q <= 1'b0;
      end
   end

   // millisecond time base, free running
   tick_counter #(.WIDTH(20)) u_ms_base (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .restart  (1'b0),
      .count_en (1'b1),
      .limit    (MS_LIMIT),
      .wrap     (ms_tick)
   );

   // force lifetime in milliseconds, restarted by every control write
   tick_counter #(.WIDTH(20)) u_force_timer (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .restart  (ctrl_wr_w || !force_q),
      .count_en (ms_tick),
      .limit    (FORCE_LIMIT),
      .wrap     (force_expired)
   );

   // ========================================================================
   // supervision state machine
   // watch the relay control level, not any one stage
   assign sup_w = (sel_q == `SEL_SECOND) ? trip_output_two : trip_output_one;

   // next state and events
   always @* begin
      state_d   = state_q;
      elapsed_d = elapsed_q;
      start_ev  = 1'b0;
      trip_ev   = 1'b0;
      drop_ev   = 1'b0;
      if (status_wr_w && force_q) begin
         // test forcing of start and trip
         if (hwdata[`ST_TRIPPED_BIT])
            state_d = S_TRIPPED;
         else if (hwdata[`ST_STARTED_BIT])
            state_d = S_STARTED;
         else
            state_d = S_IDLE;
         elapsed_d = 20'h0_0000;
      end else if (!forced_q) begin
         case (state_q)
            S_IDLE: begin
               if (stage_block) begin
                  state_d = S_BLOCKED;
               end else if (sup_w) begin
                  state_d   = S_STARTED;
                  elapsed_d = 20'h0_0000;
                  start_ev  = 1'b1;
               end
            end
            S_BLOCKED: begin
               if (!stage_block)
                  state_d = S_IDLE;
            end
            S_STARTED: begin
               if (stage_block) begin
                  state_d = S_BLOCKED;
               end else if (!sup_w) begin
                  state_d   = S_IDLE;
                  elapsed_d = 20'h0_0000;
                  drop_ev   = 1'b1;
               end else if (ms_tick) begin
                  // trip once the command outlasts the operate time
                  if (elapsed_q >= optime_q) begin
                     state_d = S_TRIPPED;
                     trip_ev = 1'b1;
                  end else begin
                     elapsed_d = elapsed_q + 20'h0_0001;
                  end
               end
            end
            default: begin
               // backup held until primary relay resets
               if (stage_block)
                  state_d = S_BLOCKED;
               else if (!sup_w)
                  state_d = S_IDLE;
            end
         endcase
      end
   end

   // state registers and outputs
   always @(posedge mclk) begin
      if (!rst_n) begin
         state_q       <= S_IDLE;
         elapsed_q     <= 20'h0_0000;
         forced_q      <= 1'b0;
         backup_relay  <= 1'b0;
         stage_started <= 1'b0;
         stage_tripped <= 1'b0;
      end else begin
         state_q   <= state_d;
         elapsed_q <= elapsed_d;
         // a forced state holds until the force flag drops
         if (!force_q)
            forced_q <= 1'b0;
         else if (status_wr_w)
            forced_q <= 1'b1;
         // backup drives its own output, never the primary
         backup_relay  <= (state_d == S_TRIPPED);
         stage_started <= (state_d == S_STARTED);
         stage_tripped <= (state_d == S_TRIPPED);
      end
   end

   // ========================================================================
   // counters
   // a count in the clear cycle survives as one
   always @(posedge mclk) begin
      if (!rst_n) begin
         start_cnt_q <= 32'h0000_0000;
         trip_cnt_q  <= 32'h0000_0000;
      end else begin
         if (ctrl_wr_w && hwdata[`CTRL_CLR_ST_BIT])
            start_cnt_q <= {31'h0000_0000, start_ev};
         else if (start_ev)
            start_cnt_q <= start_cnt_q + 32'h0000_0001;
         if (ctrl_wr_w && hwdata[`CTRL_CLR_TR_BIT])
            trip_cnt_q <= {31'h0000_0000, trip_ev};
         else if (trip_ev)
            trip_cnt_q <= trip_cnt_q + 32'h0000_0001;
      end
   end

   // ========================================================================
   // fault records
   // early drop: elapsed as a share of the operate time
   assign pct_num_w = {8'h00, elapsed_q} * 28'h000_0064;
   assign rec_wr_w  = trip_ev || div_done;
   assign rec_pct_w = trip_ev ? `FULL_PCT : div_pct;

   percent_divider u_pct (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .start    (drop_ev),
      .dividend (pct_num_w),
      .divisor  (optime_q),
      .busy     (div_busy),
      .done     (div_done),
      .quotient (div_pct)
   );

   // stamp taken when the fault starts, to the millisecond
   always @(posedge mclk) begin
      if (!rst_n) begin
         pend_date_q <= 32'h0000_0000;
         pend_time_q <= 32'h0000_0000;
      end else if (start_ev && !div_busy) begin
         // a start inside the short divide keeps the older stamp intact
         pend_date_q <= date_stamp;
         pend_time_q <= time_stamp;
      end
   end

   // ring of eight, oldest slot overwritten first
   always @(posedge mclk) begin
      if (!rst_n) begin
         wr_ptr_q <= 3'h0;
         fill_q   <= 4'h0;
      end else if (rec_wr_w) begin
         wr_ptr_q <= wr_ptr_q + 3'h1;
         if (fill_q != 4'h8)
            fill_q <= fill_q + 4'h1;
      end
   end

   // record memory, no reset needed; fill count says what is valid
   always @(posedge mclk) begin
      if (rec_wr_w) begin
         date_mem[wr_ptr_q] <= pend_date_q;
         time_mem[wr_ptr_q] <= pend_time_q;
         elapsed_delay_percent_mem[wr_ptr_q] <= rec_pct_w;
      end
   end

endmodule // breaker_failure_stage

// [hdl/breaker_failure_regs.vh]
/*
 * register map, field positions, reset values and timing counts of the
 * breaker failure stage.
 * assumes: included by bare name from the design files; definitions only.
 */
`ifndef BREAKER_FAILURE_REGS_VH
`define BREAKER_FAILURE_REGS_VH

// ==========================================================================
// register byte offsets
`define CTRL_OFS         8'h00
`define OPTIME_OFS       8'h04
`define STATUS_OFS       8'h08
`define START_CNT_OFS    8'h0C
`define TRIP_CNT_OFS     8'h10
`define REC_SEL_OFS      8'h14
`define REC_DATE_OFS     8'h18
`define REC_TIME_OFS     8'h1C
`define REC_ELAPSED_DELAY_PERCENT_OFS     8'h20
`define REC_FILL_OFS     8'h24

// ==========================================================================
// field positions
`define CTRL_FORCE_BIT   0
`define CTRL_SEL_LSB     1
`define CTRL_SEL_MSB     2
`define CTRL_CLR_ST_BIT  8
`define CTRL_CLR_TR_BIT  9
`define ST_BLOCKED_BIT   0
`define ST_STARTED_BIT   1
`define ST_TRIPPED_BIT   2

// ==========================================================================
// reset values, relay selection codes and the full percentage
`define SEL_RST          2'h1
`define OPTIME_RST       20'h0_0064
`define SEL_FIRST        2'h1
`define SEL_SECOND       2'h2
`define FULL_PCT         7'h64

// ==========================================================================
// timing: one millisecond time base, five minute force timeout
`define CLK_PERIOD_NS    8
`define MS_IN_NS         1000000
`define MS_CYCLES        (`MS_IN_NS / `CLK_PERIOD_NS)
`define FORCE_MINUTES    5
`define MS_PER_MINUTE    60000
`define FORCE_MS         (`FORCE_MINUTES * `MS_PER_MINUTE)
`define DIV_STEPS        5'h1C

`endif

// [hdl/tick_counter.v]
/*
 * wrapping event counter: pulses wrap once every limit enabled cycles.
 * assumes: limit held steady while counting; restart has priority.
 */
`timescale 1ns/100ps

module tick_counter #(
   parameter WIDTH = 20
) (
   input  wire             mclk,      // system clock
   input  wire             rst_n,     // synchronous reset, active low
   input  wire             restart,   // zero the count
   input  wire             count_en,  // advance by one
   input  wire [WIDTH-1:0] limit,     // events per wrap
   output reg              wrap       // one-cycle pulse at wrap
);

   reg [WIDTH-1:0] cnt_q;             // events so far

   // ========================================================================
   // counting
   // count, wrap and flag the boundary
   always @(posedge mclk) begin
      if (!rst_n) begin
         cnt_q <= {WIDTH{1'b0}};
         wrap  <= 1'b0;
      end else begin
         wrap <= 1'b0;
         if (restart) begin
            cnt_q <= {WIDTH{1'b0}};
         end else if (count_en) begin
            // compare with limit-1 so the wrap lands exactly on limit events
            if (cnt_q == limit - {{(WIDTH-1){1'b0}}, 1'b1}) begin
               cnt_q <= {WIDTH{1'b0}};
               wrap  <= 1'b1;
            end else begin
               cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // tick_counter

// [hdl/percent_divider.v]
/*
 * serial restoring divider giving a percentage clamped to 100.
 * assumes: start only while busy is low; one quotient bit per clock.
 */
`timescale 1ns/100ps
`include "breaker_failure_regs.vh"

module percent_divider (
   input  wire        mclk,      // system clock
   input  wire        rst_n,     // synchronous reset, active low
   input  wire        start,     // begin a division
   input  wire [27:0] dividend,  // elapsed time times 100
   input  wire [19:0] divisor,   // operate time
   output reg         busy,      // division in progress
   output reg         done,      // one-cycle pulse, quotient valid
   output reg  [6:0]  quotient   // result, 0 to 100
);

   reg  [27:0] num_q;            // dividend shifting out, quotient in
   reg  [19:0] div_q;            // divisor held for the whole run
   reg  [20:0] rem_q;            // partial remainder
   reg  [4:0]  step_q;           // steps left
   wire [20:0] shift_w;          // remainder with next bit
   wire        ge_w;             // subtract succeeds
   wire [27:0] next_num_w;       // number after this step

   assign shift_w    = {rem_q[19:0], num_q[27]};
   assign ge_w       = (shift_w >= {1'b0, div_q});
   assign next_num_w = {num_q[26:0], ge_w};

   // ========================================================================
   // division steps
   // a zero divisor gives all ones, which clamps to a full percentage
   always @(posedge mclk) begin
      if (!rst_n) begin
         num_q    <= 28'h000_0000;
         div_q    <= 20'h0_0000;
         rem_q    <= 21'h00_0000;
         step_q   <= 5'h00;
         busy     <= 1'b0;
         done     <= 1'b0;
         quotient <= 7'h00;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            num_q  <= dividend;
            div_q  <= divisor;
            rem_q  <= 21'h00_0000;
            step_q <= `DIV_STEPS;
            busy   <= 1'b1;
         end else if (busy) begin
            rem_q  <= ge_w ? (shift_w - {1'b0, div_q}) : shift_w;
            num_q  <= next_num_w;
            step_q <= step_q - 5'h01;
            if (step_q == 5'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
               // clamp: anything at or past the operate time reads 100
               if (next_num_w >= {21'h00_0000, `FULL_PCT})
                  quotient <= `FULL_PCT;
               else
                  quotient <= next_num_w[6:0];
            end
         end
      end
   end

endmodule // percent_divider

// [tb/trip_relay_pair.sv]
/* far-side model: the two primary trip relays.
   assumes: the bench commands the coils on mclk */
`timescale 1ns/100ps
module trip_relay_pair (
   input  wire       mclk,            // system clock
   input  wire [1:0] cmd,             // coil commands, bit0 relay one
   output reg        trip_output_one, // first relay control level
   output reg        trip_output_two  // second relay control level
);
   always @(posedge mclk) begin
      {trip_output_two, trip_output_one} <= cmd;
   end
endmodule // trip_relay_pair

// [tb/breaker_failure_stage_props.sv]
/* port checker of the breaker failure stage.
   assumes: the relay selection changes only while both relays are idle */
`timescale 1ns/100ps
module breaker_failure_stage_props (
   input wire       mclk,            // system clock
   input wire       rst_n,           // synchronous reset, active low
   input wire       trip_output_one, // first relay level
   input wire       trip_output_two, // second relay level
   input wire       stage_block,     // blocking level
   input wire       backup_relay,    // backup output
   input wire [1:0] cbm_relay_sel,   // relay selection
   input wire       stage_started,   // timing
   input wire       stage_tripped    // tripped
);
   // supervised level as the selection picks it
   wire sup = (cbm_relay_sel == 2'h2) ? trip_output_two : trip_output_one;
   wire hold_ok = sup & ~stage_block; // keeps the backup up
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence idle_arm_s; !stage_started && !stage_tripped && hold_ok; endsequence
   sequence rise_s; $rose(backup_relay); endsequence
   tripped_backup_a: assert property (stage_tripped == backup_relay)
      else $error("backup differs from trip state");
   one_state_a: assert property (!(stage_started && stage_tripped))
      else $error("started and tripped together");
   sel_legal_a: assert property (cbm_relay_sel == 2'h1 || cbm_relay_sel == 2'h2)
      else $error("relay selection out of range");
   block_quiet_a: assert property (stage_block |=> !stage_started && !stage_tripped)
      else $error("blocked stage active");
   start_level_a: assert property (idle_arm_s |=> stage_started)
      else $error("no start on trip level");
   early_drop_a: assert property (stage_started && $fell(sup) |=> !stage_started && !stage_tripped)
      else $error("early drop not reset");
   backup_hold_a: assert property (backup_relay |=> backup_relay == $past(hold_ok))
      else $error("backup not tied to primary");
   trip_cause_a: assert property (rise_s |-> $past(stage_started) && $past(hold_ok))
      else $error("backup without timed start");
endmodule // breaker_failure_stage_props
bind breaker_failure_stage breaker_failure_stage_props props (.mclk(mclk), .rst_n(rst_n),
   .trip_output_one(trip_output_one), .trip_output_two(trip_output_two),
   .stage_block(stage_block), .backup_relay(backup_relay), .cbm_relay_sel(cbm_relay_sel),
   .stage_started(stage_started), .stage_tripped(stage_tripped));

// [tb/breaker_failure_stage_test.sv]
/* self-checking bench of the breaker failure stage.
   assumes: shortened millisecond and force timeout parameters */
`timescale 1ns/100ps
`include "breaker_failure_regs.vh"
module breaker_failure_stage_test;
   localparam MS = 10;  // clocks per shortened millisecond
   localparam OPT = 3;  // operate time in ms
   reg         mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, stage_block = 0;
   reg  [1:0]  htrans = 0, cmd = 0;
   reg  [2:0]  hsize = 3'h2;
   reg  [31:0] haddr = 0, hwdata = 0, rd;
   reg  [31:0] date_stamp = 32'h2024_0611, time_stamp = 32'h0123_4567;
   wire        hreadyout, hresp, trip_output_one, trip_output_two;
   wire        backup_relay, stage_started, stage_tripped;
   wire [31:0] hrdata;
   wire [1:0]  cbm_relay_sel;
   integer     n_fail = 0, checks = 0, i, n;
   breaker_failure_stage #(.MS_CYCLES(MS), .FORCE_TIMEOUT_MS(5)) DUT (.mclk(mclk),
      .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .trip_output_one(trip_output_one),
      .trip_output_two(trip_output_two), .stage_block(stage_block), .date_stamp(date_stamp),
      .time_stamp(time_stamp), .backup_relay(backup_relay), .cbm_relay_sel(cbm_relay_sel),
      .stage_started(stage_started), .stage_tripped(stage_tripped));
   trip_relay_pair relays (.mclk(mclk), .cmd(cmd), .trip_output_one(trip_output_one),
      .trip_output_two(trip_output_two));
   initial forever #4 mclk = ~mclk;
   task summarize;
      begin
         $display("checks %0d n_fail %0d", checks, n_fail);
         if (n_fail == 0 && checks > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // next rising edge with hready high, bounded
   task rdy;
      begin
         n = 0;
         @(posedge mclk);
         while (hreadyout !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n = n + 1;
         end
         if (n == 20) begin
            n_fail = n_fail + 1;
            summarize;
         end
      end
   endtask
   // one single word transfer: address phase, then data phase
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge mclk);
         hsel <= 1'b1;
         htrans <= 2'b10;
         hwrite <= w;
         haddr <= {24'h00_0000, a};
         rdy;
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= d;
         rdy;
         rd = hrdata;
      end
   endtask
   task rdc(input [7:0] a, input [31:0] exp);
      begin
         bus(1'b0, a, 32'h0000_0000);
         chk(rd, exp);
      end
   endtask
   // energise relays for cyc clocks, then leave room for release and divide
   task fault(input [1:0] c, input integer cyc);
      begin
         @(posedge mclk);
         cmd <= c;
         repeat (cyc) @(posedge mclk);
         cmd <= 2'b00;
         repeat (40) @(posedge mclk);
      end
   endtask
   initial begin
      #200_000;
      n_fail = n_fail + 1;
      summarize;
   end
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      rdc(`CTRL_OFS, 32'h0000_0002);
      bus(1'b1, `OPTIME_OFS, OPT);                      // authorised change
      @(posedge mclk);
      cmd <= 2'b01;
      i = 0;
      while (backup_relay !== 1'b1 && i < 100) begin
         @(negedge mclk);
         i = i + 1;
      end
      chk(i >= OPT * MS - 2 && i <= (OPT + 1) * MS + 4, 1);
      repeat (20) @(negedge mclk);
      chk(backup_relay, 1);
      @(posedge mclk);
      cmd <= 2'b00;
      repeat (3) @(negedge mclk);
      chk(backup_relay, 0);
      rdc(`TRIP_CNT_OFS, 1);
      rdc(`REC_ELAPSED_DELAY_PERCENT_OFS, `FULL_PCT);
      rdc(`REC_DATE_OFS, 32'h2024_0611);
      rdc(`REC_TIME_OFS, 32'h0123_4567);
      bus(1'b1, `CTRL_OFS, 32'h0000_0004);
      fault(2'b01, 60);
      rdc(`START_CNT_OFS, 1);
      fault(2'b10, 15);
      rdc(`START_CNT_OFS, 2);
      rdc(`TRIP_CNT_OFS, 1);
      bus(1'b0, `REC_ELAPSED_DELAY_PERCENT_OFS, 0);
      chk(rd > 0 && rd < `FULL_PCT, 1);
      stage_block <= 1'b1;
      fault(2'b10, 60);
      stage_block <= 1'b0;
      rdc(`START_CNT_OFS, 2);
      bus(1'b1, `CTRL_OFS, 32'h0000_0304);
      rdc(`START_CNT_OFS, 0);
      rdc(`TRIP_CNT_OFS, 0);
      bus(1'b1, `STATUS_OFS, 2);
      rdc(`STATUS_OFS, 0);
      bus(1'b1, `CTRL_OFS, 5);
      bus(1'b1, `STATUS_OFS, 2);
      rdc(`STATUS_OFS, 2);
      repeat (5 * MS + 30) @(posedge mclk);
      rdc(`CTRL_OFS, 4);
      chk(stage_started, 0);
      for (i = 0; i < 8; i = i + 1) begin
         time_stamp <= 32'h0000_0100 + i;
         fault(2'b10, 55);
      end
      rdc(`REC_FILL_OFS, 8);
      bus(1'b1, `REC_SEL_OFS, 7);
      rdc(`REC_TIME_OFS, 32'h0000_0100);
      bus(1'b1, `REC_SEL_OFS, 0);
      rdc(`REC_TIME_OFS, 32'h0000_0107);
      rdc(`TRIP_CNT_OFS, 8);
      chk({hresp, cbm_relay_sel}, 2);
      summarize;
   end
endmodule // breaker_failure_stage_test
